// ---- core/led_driver_serial_latch_ctrl.sv ----
// What this block does
// - each shift clock rising edge advances the chain that mode selects
// - error pin is open drain, pulled low on open LED or overtemperature
// - mode low, latch rising edge copies on/off chain into on/off registers
// - mode high, correction registers follow the correction chain while latch high
// - mode high with latch low, correction registers hold regardless of shifting
// - mode low, the shift path is exactly sixteen bits, one per channel
// - correction packet is 112 bits, channel fifteen MSB first, channel zero LSB last
// - serial output shows the end of the selected chain for cascading
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module led_driver_serial_latch_ctrl
(
    // system clock, reset and enable
    input  wire logic                                 clk_in,
    input  wire logic                                 reset_in,
    input  wire logic                                 ce_in,
    // serial link
    input  wire logic                                 shift_clk_in,
    input  wire logic                                 serial_data_in,
    input  wire logic                                 mode_in,
    input  wire logic                                 latch_strobe_in,
    output logic                                      serial_data_out,
    // error detection and open-drain error pin
    input  wire logic                                 open_led_detect_in,
    input  wire logic                                 overtemp_flag_in,
    input  wire logic                                 error_flag_n_in,
    output logic                                      error_flag_n_out,
    output logic                                      error_flag_n_oe_n_out,
    // latched channel data
    output logic [led_drv_pkg::CHANNELS-1:0]          channel_on_out,
    output logic [led_drv_pkg::DC_CHAIN-1:0]          brightness_correction_out,
    // wishbone slave
    input  wire logic                                 wb_cyc_in,
    input  wire logic                                 wb_stb_in,
    input  wire logic                                 wb_we_in,
    input  wire logic [led_drv_pkg::ADDR_W-1:0]       wb_adr_in,
    input  wire logic [led_drv_pkg::SEL_W-1:0]        wb_sel_in,
    input  wire logic [led_drv_pkg::DATA_W-1:0]       wb_dat_in,
    output logic      [led_drv_pkg::DATA_W-1:0]       wb_dat_out,
    output logic                                      wb_ack_out
);
    import led_drv_pkg::*;

    // link domain

    logic [ONOFF_CHAIN-1:0] onoff_shift_r;
    logic [ONOFF_CHAIN-1:0] onoff_shift_nxt;
    logic [DC_CHAIN-1:0]    dc_shift_r;
    logic [DC_CHAIN-1:0]    dc_shift_nxt;
    logic                   serial_out_r;
    logic                   serial_out_nxt;

    // shift the chain that mode selects, msb first in
    always_comb begin
        onoff_shift_nxt = onoff_shift_r;
        dc_shift_nxt    = dc_shift_r;
        if (mode_in) begin
            dc_shift_nxt = {dc_shift_r[DC_CHAIN-2:0], serial_data_in};
        end else begin
            onoff_shift_nxt = {onoff_shift_r[ONOFF_CHAIN-2:0], serial_data_in};
        end
        // cascade output from the end of the selected chain
        serial_out_nxt = mode_in ? dc_shift_nxt[DC_CHAIN-1]
                                 : onoff_shift_nxt[ONOFF_CHAIN-1];
    end

    // chains and cascade bit on the shift clock
    always_ff @(posedge shift_clk_in or posedge reset_in) begin
        if (reset_in) begin
            onoff_shift_r <= ONOFF_RESET;
            dc_shift_r    <= DC_RESET;
            serial_out_r  <= 1'b0;
        end else begin
            onoff_shift_r <= onoff_shift_nxt;
            dc_shift_r    <= dc_shift_nxt;
            serial_out_r  <= serial_out_nxt;
        end
    end

    // cascade output straight from its flop
    assign serial_data_out = serial_out_r;

    // pin synchronisers

    logic [SYNC_W-1:0] async_lvl;
    logic [SYNC_W-1:0] sync_lvl;

    // latch, mode and detector levels arrive unrelated to clk_in
    always_comb begin
        async_lvl                = '0;
        async_lvl[SYNC_LATCH]    = latch_strobe_in;
        async_lvl[SYNC_MODE]     = mode_in;
        async_lvl[SYNC_OPEN_LED] = open_led_detect_in;
        async_lvl[SYNC_OVERTEMP] = overtemp_flag_in;
        async_lvl[SYNC_ERR_PIN]  = error_flag_n_in;
    end

    // two flops per lane before any logic reads them
    pin_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .ce_in    (ce_in),
        .async_in (async_lvl),
        .sync_out (sync_lvl)
    );

    logic latch_s;
    logic mode_s;
    logic open_led_s;
    logic overtemp_s;
    logic err_pin_s;

    // named views of the synchronised lanes
    assign latch_s    = sync_lvl[SYNC_LATCH];
    assign mode_s     = sync_lvl[SYNC_MODE];
    assign open_led_s = sync_lvl[SYNC_OPEN_LED];
    assign overtemp_s = sync_lvl[SYNC_OVERTEMP];
    assign err_pin_s  = sync_lvl[SYNC_ERR_PIN];

    // latch control

    logic latch_d_r;
    logic latch_d_nxt;
    logic latch_rise;
    logic onoff_load;
    logic dc_load;

    // the chains are quiet once latch is raised, so the words are sampled settled
    assign latch_rise = latch_s & ~latch_d_r;
    assign onoff_load = ce_in & ~mode_s & latch_rise;
    assign dc_load    = ce_in & mode_s & latch_s;

    // delayed latch for the rising edge, frozen with ce_in
    always_comb begin
        latch_d_nxt = ce_in ? latch_s : latch_d_r;
    end

    // latch history register
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            latch_d_r <= 1'b0;
        end else begin
            latch_d_r <= latch_d_nxt;
        end
    end

    // on/off registers
    logic [CHANNELS-1:0] onoff_r;
    logic [CHANNELS-1:0] onoff_nxt;

    always_comb begin
        onoff_nxt = onoff_r;
        if (onoff_load) begin
            onoff_nxt = onoff_shift_r;
        end
    end

    // on/off registers hold between loads
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            onoff_r <= ONOFF_RESET;
        end else begin
            onoff_r <= onoff_nxt;
        end
    end

    // on/off outputs
    assign channel_on_out = onoff_r;

    // correction registers, one word per channel
    logic [DC_CHAIN-1:0] dc_r;
    logic [DC_CHAIN-1:0] dc_nxt;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_dc
        // transparent while latched high, held while low
        assign dc_nxt[ch*DC_BITS +: DC_BITS] = dc_load ? dc_shift_r[ch*DC_BITS +: DC_BITS]
                                                       : dc_r[ch*DC_BITS +: DC_BITS];
    end

    // correction words
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dc_r <= DC_RESET;
        end else begin
            dc_r <= dc_nxt;
        end
    end

    // correction outputs
    assign brightness_correction_out = dc_r;

    // error output

    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic              err_drive_r;
    logic              err_drive_nxt;
    logic              err_level_r;
    logic              err_oe_n_r;
    logic              err_oe_n_nxt;

    // pull the pin low while an enabled detector reports
    always_comb begin
        err_drive_nxt = err_drive_r;
        if (ce_in) begin
            err_drive_nxt = (open_led_s & ctrl_r[CTRL_LED_EN_BIT])
                          | (overtemp_s & ctrl_r[CTRL_TEMP_EN_BIT]);
        end
        err_oe_n_nxt = ~err_drive_nxt;
    end

    // detector drive and pin enable, released at reset
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            err_drive_r <= 1'b0;
            err_level_r <= 1'b0;
            err_oe_n_r  <= 1'b1;
        end else begin
            err_drive_r <= err_drive_nxt;
            err_level_r <= 1'b0; // open drain only ever drives low
            err_oe_n_r  <= err_oe_n_nxt;
        end
    end

    // pin outputs straight from their flops
    assign error_flag_n_out      = err_level_r;
    assign error_flag_n_oe_n_out = err_oe_n_r;

    // update flags

    logic onoff_upd_r;
    logic onoff_upd_nxt;
    logic dc_upd_r;
    logic dc_upd_nxt;
    logic bus_req;
    logic bus_wr;
    logic status_wr;

    // accepted request and status write strobes
    assign bus_req   = wb_cyc_in & wb_stb_in & ~wb_ack_out & ce_in;
    assign bus_wr    = bus_req & wb_we_in;
    assign status_wr = bus_wr & (wb_adr_in[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2]) & wb_sel_in[0];

    // sticky, write one to clear, a new load wins over the clear
    always_comb begin
        onoff_upd_nxt = onoff_upd_r;
        dc_upd_nxt    = dc_upd_r;
        if (status_wr & wb_dat_in[STAT_ONOFF_UPD_BIT]) begin
            onoff_upd_nxt = 1'b0;
        end
        if (status_wr & wb_dat_in[STAT_DC_UPD_BIT]) begin
            dc_upd_nxt = 1'b0;
        end
        if (onoff_load) begin
            onoff_upd_nxt = 1'b1;
        end
        if (dc_load) begin
            dc_upd_nxt = 1'b1;
        end
    end

    // sticky update flags
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            onoff_upd_r <= 1'b0;
            dc_upd_r    <= 1'b0;
        end else begin
            onoff_upd_r <= onoff_upd_nxt;
            dc_upd_r    <= dc_upd_nxt;
        end
    end

    // wishbone slave

    logic              ack_r;
    logic              ack_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] status_word;
    logic [3:0]        dc_idx;

    // channel index of a correction read
    assign dc_idx = wb_adr_in[5:2];

    // status word from live state
    always_comb begin
        status_word                     = '0;
        status_word[STAT_OPEN_LED_BIT]  = open_led_s;
        status_word[STAT_OVERTEMP_BIT]  = overtemp_s;
        status_word[STAT_ERR_PIN_BIT]   = err_pin_s;
        status_word[STAT_MODE_BIT]      = mode_s;
        status_word[STAT_LATCH_BIT]     = latch_s;
        status_word[STAT_ONOFF_UPD_BIT] = onoff_upd_r;
        status_word[STAT_DC_UPD_BIT]    = dc_upd_r;
        status_word[STAT_ERR_DRIVE_BIT] = err_drive_r;
    end

    // one-cycle ack, unmapped reads return zero
    always_comb begin
        ack_nxt   = ce_in ? bus_req : ack_r;
        rdata_nxt = rdata_r;
        ctrl_nxt  = ctrl_r;
        if (bus_req) begin
            rdata_nxt = '0;
            if (wb_adr_in[ADDR_W-1:6] == DC_BASE_OFS[ADDR_W-1:6]) begin
                rdata_nxt = DATA_W'(dc_r[int'(dc_idx)*DC_BITS +: DC_BITS]);
            end else if (wb_adr_in[ADDR_W-1:2] == ONOFF_OFS[ADDR_W-1:2]) begin
                rdata_nxt = DATA_W'(onoff_r);
            end else if (wb_adr_in[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2]) begin
                rdata_nxt = status_word;
            end else if (wb_adr_in[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) begin
                rdata_nxt = DATA_W'(ctrl_r);
                if (wb_we_in & wb_sel_in[0]) begin
                    ctrl_nxt = wb_dat_in[CTRL_W-1:0];
                end
            end
        end
    end

    // ack, read data and control register
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
            ctrl_r  <= CTRL_RESET;
        end else begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r  <= ctrl_nxt;
        end
    end

    // bus outputs
    assign wb_ack_out = ack_r;
    assign wb_dat_out = rdata_r;

endmodule

`default_nettype wire

// ---- core/led_drv_pkg.sv ----
package led_drv_pkg;

    // chain geometry
    localparam int CHANNELS    = 16;
    localparam int DC_BITS     = 7;
    localparam int ONOFF_CHAIN = 16;
    localparam int DC_CHAIN    = 112;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W  = 4;

    // register byte offsets
    localparam logic [7:0] ONOFF_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam logic [7:0] CTRL_OFS    = 8'h08;
    localparam logic [7:0] DC_BASE_OFS = 8'h40;

    // control register fields
    localparam int         CTRL_W            = 2;
    localparam int         CTRL_LED_EN_BIT   = 0;
    localparam int         CTRL_TEMP_EN_BIT  = 1;
    localparam logic [1:0] CTRL_RESET        = 2'h3;

    // status register fields
    localparam int STAT_OPEN_LED_BIT   = 0;
    localparam int STAT_OVERTEMP_BIT   = 1;
    localparam int STAT_ERR_PIN_BIT    = 2;
    localparam int STAT_MODE_BIT       = 3;
    localparam int STAT_LATCH_BIT      = 4;
    localparam int STAT_ONOFF_UPD_BIT  = 5;
    localparam int STAT_DC_UPD_BIT     = 6;
    localparam int STAT_ERR_DRIVE_BIT  = 7;

    // synchroniser lanes
    localparam int SYNC_W        = 5;
    localparam int SYNC_LATCH    = 0;
    localparam int SYNC_MODE     = 1;
    localparam int SYNC_OPEN_LED = 2;
    localparam int SYNC_OVERTEMP = 3;
    localparam int SYNC_ERR_PIN  = 4;

    // reset values of the shifted and latched data
    localparam logic [15:0]  ONOFF_RESET = 16'h0000;
    localparam logic [111:0] DC_RESET    = 112'h0;

endpackage

// ---- core/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser for a group of asynchronous levels
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic             ce_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] stable_r;
    logic [WIDTH-1:0] stable_nxt;

    // first stage feeds only the second, both frozen with ce_in
    always_comb begin
        meta_nxt   = ce_in ? async_in : meta_r;
        stable_nxt = ce_in ? meta_r : stable_r;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_r   <= '0;
            stable_r <= '0;
        end else begin
            meta_r   <= meta_nxt;
            stable_r <= stable_nxt;
        end
    end

    assign sync_out = stable_r;

endmodule

`default_nettype wire

// ---- verification/led_driver_serial_latch_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_latch_ctrl_properties (
    // clock and reset
    input wire logic         clk_in,
    input wire logic         reset_in,
    input wire logic         ce_in,
    // link and detectors
    input wire logic         mode_in,
    input wire logic         latch_strobe_in,
    input wire logic         open_led_detect_in,
    input wire logic         overtemp_flag_in,
    // driven pins
    input wire logic         error_flag_n_out,
    input wire logic         error_flag_n_oe_n_out,
    input wire logic [15:0]  channel_on_out,
    input wire logic [111:0] brightness_correction_out,
    // bus handshake
    input wire logic         wb_cyc_in,
    input wire logic         wb_stb_in,
    input wire logic         wb_ack_out
);
    // all checks on the system clock
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && ce_in |=> wb_ack_out)
        else $error("no ack after request");
    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    a_err_drive_zero: assert property (error_flag_n_out == 1'b0)
        else $error("error pin driven high");
    a_err_pull_low: assert property (((open_led_detect_in || overtemp_flag_in) && ce_in) [*4]
        |-> !error_flag_n_oe_n_out)
        else $error("error pin not pulled low");
    a_err_release: assert property ((!open_led_detect_in && !overtemp_flag_in && ce_in) [*4]
        |-> error_flag_n_oe_n_out)
        else $error("error pin not released");
    a_onoff_hold: assert property (!latch_strobe_in [*6] |-> $stable(channel_on_out))
        else $error("on/off changed without latch");
    a_onoff_mode_hi: assert property (mode_in [*6] |-> $stable(channel_on_out))
        else $error("on/off changed in correction mode");
    a_dc_hold: assert property (!latch_strobe_in [*6] |-> $stable(brightness_correction_out))
        else $error("correction changed with latch low");
endmodule
bind led_driver_serial_latch_ctrl led_driver_serial_latch_ctrl_properties chk_u (
    .clk_in, .reset_in, .ce_in, .mode_in, .latch_strobe_in, .open_led_detect_in, .overtemp_flag_in,
    .error_flag_n_out, .error_flag_n_oe_n_out, .channel_on_out, .brightness_correction_out,
    .wb_cyc_in, .wb_stb_in, .wb_ack_out);
`default_nettype wire

// ---- verification/led_driver_serial_latch_ctrl_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module led_driver_serial_latch_ctrl_tb_top;
    import led_drv_pkg::*;
    // pins of the driver
    logic                clk_in = 1'b0, reset_in = 1'b1, ce_in = 1'b1;
    logic                open_led_detect_in = 1'b0, overtemp_flag_in = 1'b0;
    logic                shift_clk_in, serial_data_in, mode_in, latch_strobe_in, serial_data_out;
    logic                error_flag_n_in, error_flag_n_out, error_flag_n_oe_n_out, wb_ack_out;
    logic                wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
    logic [ADDR_W-1:0]   wb_adr_in = '0;
    logic [SEL_W-1:0]    wb_sel_in = 4'hF;
    logic [DATA_W-1:0]   wb_dat_in = '0, wb_dat_out;
    logic [CHANNELS-1:0] channel_on_out;
    logic [DC_CHAIN-1:0] brightness_correction_out;
    // reference model state
    logic [15:0]         on_chain = '0, exp_on = '0;
    logic [111:0]        dc_chain = '0, exp_dc = '0, v = '0;
    logic [31:0]         rs = 32'h0D9D, q;
    logic                casc_exp = 1'b0;
    int                  n_fail = 0, tests_run = 0;

    always #50 clk_in = ~clk_in;
    // open-drain pin with pull-up
    assign error_flag_n_in = error_flag_n_oe_n_out ? 1'b1 : error_flag_n_out;

    led_driver_serial_latch_ctrl dut_u (.clk_in, .reset_in, .ce_in, .shift_clk_in, .serial_data_in,
        .mode_in, .latch_strobe_in, .serial_data_out, .open_led_detect_in, .overtemp_flag_in,
        .error_flag_n_in, .error_flag_n_out, .error_flag_n_oe_n_out, .channel_on_out,
        .brightness_correction_out, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in,
        .wb_dat_in, .wb_dat_out, .wb_ack_out);
    serial_ctrl_model ctrl_u (.sclk_out(shift_clk_in), .sdat_out(serial_data_in),
        .mode_out(mode_in), .latch_out(latch_strobe_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [111:0] seen, input logic [111:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one classic bus cycle, read data into q
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= a;
        wb_dat_in <= d;
        do begin
            @(posedge clk_in);
        end while (wb_ack_out !== 1'b1);
        q = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask

    // frame through the partner and the model chains
    task automatic shift(input logic m, input int n, input logic [111:0] pk);
        ctrl_u.send(m, n, pk);
        for (int i = n - 1; i >= 0; i--) begin
            if (m) dc_chain = {dc_chain[110:0], pk[i]};
            else on_chain = {on_chain[14:0], pk[i]};
        end
        if (n > 0) casc_exp = m ? dc_chain[111] : on_chain[15];
        chk("cascade out", serial_data_out, casc_exp);
    endtask

    task automatic conclude();
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // watchdog
    initial begin
        #1000000;
        n_fail++;
        conclude();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        chk("on rst", channel_on_out, ONOFF_RESET);
        chk("oe rst", error_flag_n_oe_n_out, 1'b1);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", q, CTRL_RESET);
        wb(1'b1, CTRL_OFS, 32'h1);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl wr", q, 32'h1);
        wb(1'b1, CTRL_OFS, 32'h3);
        wb(1'b1, 8'h20, 32'hFFFF);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", q, 32'h0);
        // on/off frames, the first overlong
        for (int k = 0; k < 3; k++) begin
            rs = lfsr(rs);
            shift(1'b0, (k == 0) ? 20 : 16, {80'h0, rs});
            chk("on held", channel_on_out, exp_on);
            ctrl_u.pulse();
            exp_on = on_chain;
            chk("on", channel_on_out, exp_on);
            wb(1'b0, ONOFF_OFS, 32'h0);
            chk("on reg", q, exp_on);
            wb(1'b0, STATUS_OFS, 32'h0);
            chk("on upd", q[STAT_ONOFF_UPD_BIT], 1'b1);
            wb(1'b1, STATUS_OFS, 32'h1 << STAT_ONOFF_UPD_BIT);
        end
        // correction frames, latched once then shifted with latch low
        for (int k = 0; k < 2; k++) begin
            repeat (4) begin
                rs = lfsr(rs);
                v = {v[79:0], rs};
            end
            shift(1'b1, 112, v);
            chk("dc held", brightness_correction_out, exp_dc);
            chk("on kept", channel_on_out, exp_on);
            if (k == 0) ctrl_u.pulse();
            if (k == 0) exp_dc = dc_chain;
            chk("dc", brightness_correction_out, exp_dc);
        end
        wb(1'b0, STATUS_OFS, 32'h0);
        chk("dc upd", q[STAT_DC_UPD_BIT], 1'b1);
        chk("upd clr", q[STAT_ONOFF_UPD_BIT], 1'b0);
        for (int c = 0; c < 16; c++) begin
            wb(1'b0, DC_BASE_OFS + 8'(4 * c), 32'h0);
            chk("dc reg", q, exp_dc[7 * c +: 7]);
        end
        // on/off chain untouched by correction shifting
        shift(1'b0, 0, v);
        ctrl_u.pulse();
        chk("on relatch", channel_on_out, exp_on);
        // a frozen enable holds the error pin
        @(posedge clk_in);
        ce_in <= 1'b0;
        open_led_detect_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk("oe frozen", error_flag_n_oe_n_out, 1'b1);
        ce_in <= 1'b1;
        // each detector pulls the error pin
        for (int e = 0; e < 2; e++) begin
            open_led_detect_in <= (e == 0);
            overtemp_flag_in <= (e == 1);
            repeat (5) @(posedge clk_in);
            chk("oe low", error_flag_n_oe_n_out, 1'b0);
            wb(1'b0, STATUS_OFS, 32'h0);
            chk("status", q & 32'h87, (32'h1 << e) | 32'h80);
            open_led_detect_in <= 1'b0;
            overtemp_flag_in <= 1'b0;
            repeat (5) @(posedge clk_in);
            chk("oe rel", error_flag_n_oe_n_out, 1'b1);
        end
        conclude();
    end
endmodule
`default_nettype wire

// ---- verification/serial_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_model (
    // serial lines towards the driver
    output logic sclk_out,
    output logic sdat_out,
    output logic mode_out,
    output logic latch_out
);
    // idle lines, clock still between frames
    initial begin
        sclk_out = 1'b0;
        sdat_out = 1'b0;
        mode_out = 1'b0;
        latch_out = 1'b0;
    end
    // one frame at 160 ns per bit
    task automatic send(input logic m, input int n, input logic [111:0] pk);
        #37;
        mode_out = m;
        for (int i = n - 1; i >= 0; i--) begin
            sdat_out = pk[i];
            #80;
            sclk_out = 1'b1;
            #80;
            sclk_out = 1'b0;
        end
        #80;
        sdat_out = ~sdat_out; // stale data not held
    endtask
    // latch only once the frame is complete
    task automatic pulse();
        #120;
        latch_out = 1'b1;
        #900;
        latch_out = 1'b0;
        #500;
    endtask
endmodule
`default_nettype wire
